// [inc/rtc_defs.svh]
// Register map, field positions, reset values and counts for the clock core
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH
`define A_SEC       6'h00
`define A_MIN       6'h01
`define A_HR        6'h02
`define A_DAY       6'h03
`define A_DATE      6'h04
`define A_MON       6'h05
`define A_YEAR      6'h06
`define A_CTRL      6'h07
`define A_RAM       6'h08
`define A_LAST      6'h3f
`define N_REGS      64
`define N_SHADOW    6'd7
`define M_SEC       8'hff
`define M_MIN       8'h7f
`define M_HR        8'h7f
`define M_DAY       8'h07
`define M_DATE      8'h3f
`define M_MON       8'h1f
`define M_YEAR      8'hff
`define M_CTRL      8'h93
`define M_RAM       8'hff
`define R_SEC       8'h80
`define R_ONE       8'h01
`define R_ZERO      8'h00
`define R_CTRL      8'h03
`define B_HALT      7
`define B_12H       6
`define B_PM        5
`define B_SQUARE_WAVE_ENABLE      4
`define B_OUT       7
`define SEC_LAST    7'h59
`define HR24_LAST   6'h23
`define HR12_11     5'h11
`define HR12_12     5'h12
`define HR12_1      5'h01
`define DAY_LAST    8'h07
`define MON_LAST    8'h12
`define YEAR_LAST   8'h99
`define FEB         8'h02
`define APR         8'h04
`define JUN         8'h06
`define SEP         8'h09
`define NOV         8'h11
`define LEN28       8'h28
`define LEN29       8'h29
`define LEN30       8'h30
`define LEN31       8'h31
`define PRESC_W     15
`define BITS        4'd8
`define FIFO_D      8
`define DEV_ID_DFLT 7'h2a
`endif

// [inc/rtc_pkg.sv]
// Types shared by the clock core
package rtc_pkg;
  typedef logic [5:0] reg_ptr_t;
  typedef logic [7:0] byte_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_ADDR = 4'b0001,
    ST_AACK = 4'b0011,
    ST_PTR  = 4'b0010,
    ST_PACK = 4'b0110,
    ST_WR   = 4'b0111,
    ST_WACK = 4'b0101,
    ST_RD   = 4'b0100,
    ST_RACK = 4'b1100,
    ST_RNXT = 4'b1101
  } bus_state_t;
endpackage

// [rtl/rtc_core.sv]
// Serial clock/calendar core with user bytes, square-wave pin and write FIFO
// How it works
// - Clock registers sit at 00h-07h, user bytes at 08h-3Fh.
// - Register pointer wraps from 3Fh back to 00h during multibyte access.
// - Access opens with START, address and pointer; runs until STOP.
// - Power-fail lockout aborts transfer, clears pointer; bus engine ignores bus inputs, but START still refreshes shadow bytes.
// - All time and calendar values are kept in BCD nibbles.
// - Weekday advances at midnight, cycling 01 to 07.
// - Date rolls over by month length, including leap-year February.
// - Seconds bit 7 halts prescaler and timekeeping when set.
// - Reset loads 01/01/00, weekday 01, 00:00:00, halt bit set.
// - Hours bit 6 selects 12-hour (1) or 24-hour (0) counting.
// - Hours bit 5 is afternoon flag in 12-hour, tens digit in 24-hour.
// - START copies counters into shadow bytes; reads return the shadow.
// - Writing seconds clears the prescaler, restarting the second.
// - Written byte commits when the core drives its acknowledge.
// - Bits without a field always read back as zero.
// - With square wave off, pin level follows control bit 7.
// - Control bit 4 enables the divided square wave on the pin.
// - Rate select picks 1Hz, 4.096kHz, 8.192kHz or 32.768kHz.
// - At 1Hz, clock registers advance on the square-wave falling edge.
// - Control resets with output bit 0, enable 0, rate bits 1.
// - Pointer increments after every acknowledged data byte written.
// - Read without pointer write starts at the last pointer value.
`timescale 1ns/1ps
`include "rtc_defs.svh"

module wr_fifo #(
  parameter int W = 14,
  parameter int D = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Filling side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Draining side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL = D[AW:0];
  logic [W-1:0] mem_r [D];
  logic [AW:0]  wp_r;
  logic [AW:0]  rp_r;
  logic [AW:0]  used;

  // Extra pointer bit tells full from empty
  assign used      = wp_r - rp_r;
  assign in_ready  = used != FULL;
  assign out_valid = used != '0;
  assign out_data  = mem_r[rp_r[AW-1:0]];

  // Storage carries no reset; only pointers are control state
  always_ff @(posedge clk)
  begin
    if (in_valid && in_ready)
    begin
      mem_r[wp_r[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_r <= '0;
      rp_r <= '0;
    end
    else
    begin
      if (in_valid && in_ready)
        wp_r <= wp_r + 1'b1;
      if (out_valid && out_ready)
        rp_r <= rp_r + 1'b1;
    end
  end
endmodule // wr_fifo

module rtc_core #(
  parameter logic [6:0] DEV_ID = `DEV_ID_DFLT // Arbitrary value
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Serial bus pins
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  // Oscillator and supply monitor
  input  wire logic osc_in,
  input  wire logic power_fail,
  // Open-drain square-wave pin
  output logic      square_wave_pin,
  output logic      square_wave_oe
);
  import rtc_pkg::*;

  logic       scl_m_r, scl_s_r, scl_d_r;
  logic       sda_m_r, sda_s_r, sda_d_r;
  logic       osc_m_r, osc_s_r, osc_d_r;
  logic       pf_m_r, pf_s_r;
  logic       scl_rise, scl_fall, start_c, stop_c, osc_rise;
  bus_state_t state_r;
  logic [3:0] bit_cnt_r;
  byte_t      shift_r;
  byte_t      tx_r;
  logic       sda_oe_r;
  reg_ptr_t   ptr_r;
  byte_t      mem_r [`N_REGS];
  byte_t      sh_r [7];
  byte_t      rd_byte;
  logic [`PRESC_W-1:0] presc_r;
  logic       halt, tick, sq_lvl_r;
  logic       push, f_ready, f_valid, wr_take, byte_end;
  logic [13:0] f_data;
  reg_ptr_t   wr_addr;
  byte_t      wr_data;
  byte_t      sec_nxt, min_nxt, hr_nxt, day_nxt;
  byte_t      date_nxt, mon_nxt, year_nxt;
  logic       c_min, c_hr, c_day, c_mon, c_year;

  // Increment one BCD byte, units carrying into tens
  function automatic byte_t bcd_inc(input byte_t v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  // Leap years in 00-99: multiples of four in BCD
  function automatic logic is_leap(input byte_t y);
    is_leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                   : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
  endfunction

  // Last date of a month
  function automatic byte_t month_len(input byte_t m, input byte_t y);
    case (m)
      `FEB:    month_len = is_leap(y) ? `LEN29 : `LEN28;
      `APR,
      `JUN,
      `SEP,
      `NOV:    month_len = `LEN30;
      default: month_len = `LEN31;
    endcase
  endfunction

  // Unused bits are dropped on write so they read as zero
  function automatic byte_t reg_mask(input reg_ptr_t a);
    case (a)
      `A_SEC:  reg_mask = `M_SEC;
      `A_MIN:  reg_mask = `M_MIN;
      `A_HR:   reg_mask = `M_HR;
      `A_DAY:  reg_mask = `M_DAY;
      `A_DATE: reg_mask = `M_DATE;
      `A_MON:  reg_mask = `M_MON;
      `A_YEAR: reg_mask = `M_YEAR;
      `A_CTRL: reg_mask = `M_CTRL;
      default: reg_mask = `M_RAM;
    endcase
  endfunction

  // Pin synchronisers plus one delay stage for edge detection
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {scl_m_r, scl_s_r, scl_d_r} <= 3'b111;
      {sda_m_r, sda_s_r, sda_d_r} <= 3'b111;
      {osc_m_r, osc_s_r, osc_d_r} <= 3'b000;
      {pf_m_r, pf_s_r}            <= 2'b00;
    end
    else
    begin
      {scl_m_r, scl_s_r, scl_d_r} <= {scl_in, scl_m_r, scl_s_r};
      {sda_m_r, sda_s_r, sda_d_r} <= {sda_in, sda_m_r, sda_s_r};
      {osc_m_r, osc_s_r, osc_d_r} <= {osc_in, osc_m_r, osc_s_r};
      {pf_m_r, pf_s_r}            <= {power_fail, pf_m_r};
    end
  end

  // Bus conditions; data moves only while the clock line is low
  assign scl_rise = scl_s_r & ~scl_d_r;
  assign scl_fall = ~scl_s_r & scl_d_r;
  assign start_c  = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  assign stop_c   = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
  assign osc_rise = osc_s_r & ~osc_d_r;
  assign byte_end = scl_fall && (bit_cnt_r == `BITS);

  // Reads below the control byte come from the shadow copy
  assign rd_byte = (ptr_r < `N_SHADOW) ? sh_r[ptr_r[2:0]] : mem_r[ptr_r];

  // Commit request raised in the byte-ending cycle, one cycle before the acknowledge is driven
  assign push = (state_r == ST_WR) && byte_end && !pf_s_r;

  // Bus engine
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r   <= ST_IDLE;
      bit_cnt_r <= 4'd0;
      shift_r   <= 8'h00;
      tx_r      <= 8'h00;
      sda_oe_r  <= 1'b0;
      ptr_r     <= `A_SEC;
    end
    else if (pf_s_r)
    begin
      state_r  <= ST_IDLE;
      sda_oe_r <= 1'b0;
      ptr_r    <= `A_SEC;
    end
    else if (start_c)
    begin
      state_r   <= ST_ADDR;
      bit_cnt_r <= 4'd0;
      sda_oe_r  <= 1'b0;
    end
    else if (stop_c)
    begin
      state_r  <= ST_IDLE;
      sda_oe_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_ADDR,
        ST_PTR,
        ST_WR:
        begin
          if (scl_rise)
          begin
            shift_r   <= {shift_r[6:0], sda_s_r};
            bit_cnt_r <= bit_cnt_r + 4'd1;
          end
          else if (byte_end)
          begin
            bit_cnt_r <= 4'd0;
            if (state_r == ST_ADDR)
            begin
              // Foreign address: stay off the bus until the next START
              if (shift_r[7:1] == DEV_ID)
              begin
                sda_oe_r <= 1'b1;
                state_r  <= ST_AACK;
              end
              else
                state_r <= ST_IDLE;
            end
            else if (state_r == ST_PTR)
            begin
              ptr_r    <= shift_r[5:0];
              sda_oe_r <= 1'b1;
              state_r  <= ST_PACK;
            end
            else
            begin
              // A full FIFO answers not-acknowledge and keeps the pointer
              if (f_ready)
              begin
                sda_oe_r <= 1'b1;
                ptr_r    <= ptr_r + 6'd1;
              end
              state_r <= ST_WACK;
            end
          end
        end
        ST_AACK:
        begin
          if (scl_fall)
          begin
            if (shift_r[0])
            begin
              tx_r      <= rd_byte;
              sda_oe_r  <= ~rd_byte[7];
              bit_cnt_r <= 4'd1;
              ptr_r     <= ptr_r + 6'd1;
              state_r   <= ST_RD;
            end
            else
            begin
              sda_oe_r <= 1'b0;
              state_r  <= ST_PTR;
            end
          end
        end
        ST_PACK,
        ST_WACK:
        begin
          if (scl_fall)
          begin
            sda_oe_r <= 1'b0;
            state_r  <= ST_WR;
          end
        end
        ST_RD:
        begin
          if (byte_end)
          begin
            sda_oe_r  <= 1'b0;
            bit_cnt_r <= 4'd0;
            state_r   <= ST_RACK;
          end
          else if (scl_fall)
          begin
            tx_r      <= {tx_r[6:0], 1'b0};
            sda_oe_r  <= ~tx_r[6];
            bit_cnt_r <= bit_cnt_r + 4'd1;
          end
        end
        ST_RACK:
        begin
          // High line means the master wants no more bytes
          if (scl_rise)
            state_r <= sda_s_r ? ST_IDLE : ST_RNXT;
        end
        ST_RNXT:
        begin
          if (scl_fall)
          begin
            tx_r      <= rd_byte;
            sda_oe_r  <= ~rd_byte[7];
            bit_cnt_r <= 4'd1;
            ptr_r     <= ptr_r + 6'd1;
            state_r   <= ST_RD;
          end
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // Open drain: low is driven, high is released
  assign sda_out = 1'b0;
  assign sda_oe  = sda_oe_r;

  // Write path buffer between bus engine and register array
  wr_fifo #(
    .W (14),
    .D (`FIFO_D)
  ) u_wr_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_ready  (f_ready),
    .in_data   ({ptr_r, shift_r}),
    .out_valid (f_valid),
    .out_ready (!tick),
    .out_data  (f_data)
  );

  // A write waits one cycle when it collides with a counter update
  assign wr_take = f_valid && !tick;
  assign wr_addr = f_data[13:8];
  assign wr_data = f_data[7:0] & reg_mask(f_data[13:8]);

  // Prescaler stops while halted and restarts on a seconds write
  assign halt = mem_r[`A_SEC][`B_HALT];
  assign tick = osc_rise && !halt && (presc_r == '1);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      presc_r <= '0;
    else if (wr_take && wr_addr == `A_SEC)
      presc_r <= '0;
    else if (osc_rise && !halt)
      presc_r <= presc_r + 1'b1;
  end

  // Shadow copy of the seven counter bytes, taken at START
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 7; i++)
        sh_r[i] <= `R_ZERO;
    end
    else if (start_c)
    begin
      for (int i = 0; i < 7; i++)
        sh_r[i] <= mem_r[i];
    end
  end

  // Ripple of carries from seconds up to year
  always_comb
  begin
    c_min = mem_r[`A_SEC][6:0] == `SEC_LAST;
    sec_nxt = c_min ? {mem_r[`A_SEC][7], 7'h00}
                    : {mem_r[`A_SEC][7], 7'(bcd_inc(mem_r[`A_SEC]))};
    c_hr = mem_r[`A_MIN][6:0] == `SEC_LAST;
    min_nxt = c_hr ? `R_ZERO : bcd_inc(mem_r[`A_MIN]);
    hr_nxt = mem_r[`A_HR];
    c_day = 1'b0;
    if (mem_r[`A_HR][`B_12H])
    begin
      // Twelve-hour: 11 to 12 flips the half, midnight after 11 PM
      if (mem_r[`A_HR][4:0] == `HR12_12)
        hr_nxt[4:0] = `HR12_1;
      else if (mem_r[`A_HR][4:0] == `HR12_11)
      begin
        hr_nxt[4:0]   = `HR12_12;
        hr_nxt[`B_PM] = ~mem_r[`A_HR][`B_PM];
        c_day         = mem_r[`A_HR][`B_PM];
      end
      else
        hr_nxt[4:0] = 5'(bcd_inc({3'b000, mem_r[`A_HR][4:0]}));
    end
    else
    begin
      // Twenty-four-hour: bit 5 is the tens digit for 20-23
      c_day = mem_r[`A_HR][5:0] == `HR24_LAST;
      hr_nxt[5:0] = c_day ? 6'h00
                          : 6'(bcd_inc({2'b00, mem_r[`A_HR][5:0]}));
    end
    day_nxt = (mem_r[`A_DAY] == `DAY_LAST) ? `R_ONE : bcd_inc(mem_r[`A_DAY]);
    c_mon = mem_r[`A_DATE] == month_len(mem_r[`A_MON], mem_r[`A_YEAR]);
    date_nxt = c_mon ? `R_ONE : bcd_inc(mem_r[`A_DATE]);
    c_year = mem_r[`A_MON] == `MON_LAST;
    mon_nxt = c_year ? `R_ONE : bcd_inc(mem_r[`A_MON]);
    year_nxt = (mem_r[`A_YEAR] == `YEAR_LAST) ? `R_ZERO : bcd_inc(mem_r[`A_YEAR]);
  end

  // Register array: counters, control and user bytes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < `N_REGS; i++)
        mem_r[i] <= `R_ZERO;
      mem_r[`A_SEC]  <= `R_SEC;
      mem_r[`A_DAY]  <= `R_ONE;
      mem_r[`A_DATE] <= `R_ONE;
      mem_r[`A_MON]  <= `R_ONE;
      mem_r[`A_CTRL] <= `R_CTRL;
    end
    else
    begin
      if (tick)
      begin
        mem_r[`A_SEC] <= sec_nxt;
        if (c_min)
        begin
          mem_r[`A_MIN] <= min_nxt;
          if (c_hr)
          begin
            mem_r[`A_HR] <= hr_nxt;
            if (c_day)
            begin
              mem_r[`A_DAY]  <= day_nxt;
              mem_r[`A_DATE] <= date_nxt;
              if (c_mon)
              begin
                mem_r[`A_MON] <= mon_nxt;
                if (c_year)
                  mem_r[`A_YEAR] <= year_nxt;
              end
            end
          end
        end
      end
      // Hours format bit is stored as written; no conversion
      if (wr_take)
        mem_r[wr_addr] <= wr_data;
    end
  end

  // Pin source: divider taps or static level
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sq_lvl_r <= 1'b0;
    else if (mem_r[`A_CTRL][`B_SQUARE_WAVE_ENABLE])
    begin
      case (mem_r[`A_CTRL][1:0])
        2'b00:   sq_lvl_r <= presc_r[14];
        2'b01:   sq_lvl_r <= presc_r[2];
        2'b10:   sq_lvl_r <= presc_r[1];
        default: sq_lvl_r <= osc_s_r;
      endcase
    end
    else
      sq_lvl_r <= mem_r[`A_CTRL][`B_OUT];
  end

  // Open drain: pulls low only
  assign square_wave_pin = 1'b0;
  assign square_wave_oe  = ~sq_lvl_r;
endmodule // rtc_core

// [tb/bcd_rtc_with_sqw_and_ram_tb_top.sv]
// Self-checking bench for the clock core against a byte-map model
`timescale 1ns/1ps
module bcd_rtc_with_sqw_and_ram_tb_top;
  import rtc_pkg::*;
  localparam logic [6:0] DEV = 7'h35; // Arbitrary identity value

  logic       clk;
  logic       rst_n;
  logic       power_fail;
  logic [2:0] osc_div_r = 3'd0;
  logic       scl;
  logic       pull;
  logic       sda_oe;
  logic       sq_oe;
  wire        sda = !(pull || sda_oe);
  int         errors;
  int         samples_checked;
  int         mem[64] = '{default: 0};
  int         ptr;
  int         mask_tab[8] = '{8'hff, 8'h7f, 8'h7f, 8'h07, 8'h3f, 8'h1f, 8'hff, 8'h93};
  int         rate_tab[4] = '{0, 16, 32, 128};
  byte_t      q[$];
  byte_t      rb;
  logic       nk;

  rtc_core #(.DEV_ID(DEV)) rtc_core_inst (
    .clk             (clk),
    .rst_n           (rst_n),
    .scl_in          (scl),
    .sda_in          (sda),
    .sda_out         (),
    .sda_oe          (sda_oe),
    .osc_in          (osc_div_r[2]),
    .power_fail      (power_fail),
    .square_wave_pin (),
    .square_wave_oe  (sq_oe)
  );

  bus_master bus_master_inst (
    .clk      (clk),
    .sda      (sda),
    .scl      (scl),
    .sda_pull (pull)
  );

  // 200 MHz system clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Oscillator at 8 clocks a period, fast enough to see the dividers
  always @(posedge clk)
    osc_div_r <= osc_div_r + 3'd1;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Pointer byte then queued data; model commits each acknowledged byte
  task automatic wr(input byte_t a);
    bus_master_inst.start();
    bus_master_inst.xfer({DEV, 1'b0}, 1'b1, rb, nk);
    chk({7'h0, nk}, 8'h00);
    bus_master_inst.xfer(a, 1'b1, rb, nk);
    ptr = a & 8'h3f;
    foreach (q[i])
    begin
      bus_master_inst.xfer(q[i], 1'b1, rb, nk);
      chk({7'h0, nk}, 8'h00);
      mem[ptr] = q[i] & (ptr < 8 ? mask_tab[ptr] : 8'hff);
      ptr = (ptr + 1) % 64;
    end
    bus_master_inst.stop();
  endtask

  // Read n bytes from the current pointer, last one refused
  task automatic rd(input int n);
    bus_master_inst.start();
    bus_master_inst.xfer({DEV, 1'b1}, 1'b1, rb, nk);
    chk({7'h0, nk}, 8'h00);
    for (int i = 0; i < n; i++)
    begin
      bus_master_inst.xfer(8'hff, i == n - 1, rb, nk);
      chk(rb, mem[ptr][7:0]);
      ptr = (ptr + 1) % 64;
    end
    bus_master_inst.stop();
  endtask

  // Count pin changes over 64 oscillator periods, sampled off the edge
  task automatic edges(input int exp);
    int   n;
    logic p;
    n = 0;
    p = sq_oe;
    repeat (512)
    begin
      @(negedge clk);
      n += (sq_oe !== p);
      p = sq_oe;
    end
    chk({7'h0, (n - exp) * (n - exp) <= (exp > 0)}, 8'h01);
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Hang guard, well beyond the expected run of about 15000 clocks
  initial
  begin
    repeat (60000) @(posedge clk);
    errors++;
    finish_test();
  end

  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    power_fail = 1'b0;
    errors = 0;
    samples_checked = 0;
    mem[0] = 8'h80;
    mem[3] = 1;
    mem[4] = 1;
    mem[5] = 1;
    mem[7] = 3;
    ptr = 0;
    void'($urandom(32'h15102781));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk({7'h0, sq_oe}, 8'h01);
    rd(8);
    $display("test reset values done");
    // Random user bytes, then a pointer-only write and read back
    repeat (8) q.push_back(byte_t'($urandom));
    wr(8'h08);
    q = {};
    wr(8'h08);
    rd(8);
    $display("test user bytes done");
    // All ones in every clock register shows the unused bits reading zero
    repeat (8) q.push_back(8'hff);
    wr(8'h00);
    q = {};
    wr(8'h00);
    rd(8);
    $display("test unused bits done");
    // Pointer wraps from the top of the user bytes into seconds
    repeat (3) q.push_back(byte_t'($urandom));
    wr(8'h3e);
    q = {};
    wr(8'h3e);
    rd(3);
    $display("test wrap done");
    // Static level follows the output bit
    for (int c = 0; c < 2; c++)
    begin
      q = {c ? 8'h00 : 8'h80};
      wr(8'h07);
      repeat (4) @(posedge clk);
      chk({7'h0, sq_oe}, {7'h0, c[0]});
    end
    $display("test static pin done");
    // Run the clock with a cleared divider, then every rate
    q = {8'h00};
    wr(8'h00);
    for (int rs = 0; rs < 4; rs++)
    begin
      q = {byte_t'(8'h10 | rs)};
      wr(8'h07);
      edges(rate_tab[rs]);
    end
    // Halted prescaler freezes the divided output
    q = {8'h80};
    wr(8'h00);
    q = {8'h11};
    wr(8'h07);
    edges(0);
    $display("test square wave done");
    // Format bit only changes together with a fresh hours value: 11 PM
    q = {8'h71};
    wr(8'h02);
    q = {};
    wr(8'h02);
    rd(1);
    $display("test hours format done");
    // Foreign identity gets no acknowledge
    bus_master_inst.start();
    bus_master_inst.xfer({DEV ^ 7'h01, 1'b0}, 1'b1, rb, nk);
    chk({7'h0, nk}, 8'h01);
    bus_master_inst.stop();
    // Lockout mid-write: byte refused, pointer back to zero
    q = {};
    wr(8'h20);
    bus_master_inst.start();
    bus_master_inst.xfer({DEV, 1'b0}, 1'b1, rb, nk);
    power_fail <= 1'b1;
    bus_master_inst.xfer(8'h5a, 1'b1, rb, nk);
    chk({7'h0, nk}, 8'h01);
    power_fail <= 1'b0;
    bus_master_inst.stop();
    ptr = 0;
    rd(1);
    $display("test address and lockout done");
    finish_test();
  end
endmodule // bcd_rtc_with_sqw_and_ram_tb_top

// [tb/bus_master.sv]
// Serial bus master model: drives the clock and pulls data low
`timescale 1ns/1ps
module bus_master (
  // Clock
  input  wire logic clk,
  // Bus lines
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  // Idle bus: both lines released high
  initial
  begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  // Wait whole system clocks so every change lands on an edge
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Data falls while clock high; also serves as repeated start
  task automatic start();
    hold(3);
    sda_pull <= 1'b0;
    hold(4);
    scl <= 1'b1;
    hold(6);
    sda_pull <= 1'b1;
    hold(6);
    scl <= 1'b0;
  endtask

  // Data rises while clock high
  task automatic stop();
    hold(3);
    sda_pull <= 1'b1;
    hold(4);
    scl <= 1'b1;
    hold(6);
    sda_pull <= 1'b0;
    hold(6);
  endtask

  // Low 7 clocks, high 6: about 65 ns; data set mid-low, sampled at end of high
  task automatic bit_io(input logic b, output logic s);
    hold(3);
    sda_pull <= !b;
    hold(4);
    scl <= 1'b1;
    hold(6);
    s = sda;
    scl <= 1'b0;
  endtask

  // Eight bits MSB first, then the ninth (acknowledge) bit
  task automatic xfer(input logic [7:0] d, input logic b9, output logic [7:0] r,
                      output logic s9);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r[i]);
    bit_io(b9, s9);
  endtask
endmodule // bus_master

// [tb/rtc_core_monitor.sv]
// Port-level checker for the clock core, bound into every instance
`timescale 1ns/1ps
module rtc_core_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Oscillator, supply and square-wave pin
  input wire logic osc_in,
  input wire logic power_fail,
  input wire logic square_wave_pin,
  input wire logic square_wave_oe
);
  logic [3:0] scl_age_r;
  logic [3:0] osc_age_r;
  logic [3:0] ack_age_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Cycles since each cause; saturate so old events look stale
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_age_r <= 4'hf;
      osc_age_r <= 4'hf;
      ack_age_r <= 4'hf;
    end
    else
    begin
      scl_age_r <= $fell(scl_in) ? 4'h0 : scl_age_r + {3'h0, scl_age_r != 4'hf};
      osc_age_r <= $changed(osc_in) ? 4'h0 : osc_age_r + {3'h0, osc_age_r != 4'hf};
      ack_age_r <= sda_oe ? 4'h0 : ack_age_r + {3'h0, ack_age_r != 4'hf};
    end
  end

  property p_od_low;
    !sda_out && !square_wave_pin;
  endproperty
  a_od_low: assert property (p_od_low) else $error("open-drain value not low");

  property p_reset_state;
    !$past(rst_n) |-> square_wave_oe && !sda_oe;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("pin state after reset");

  property p_drive_start;
    $rose(sda_oe) |-> !scl_in && scl_age_r < 4'd7;
  endproperty
  a_drive_start: assert property (p_drive_start) else $error("data driven off a clock fall");

  property p_drive_end;
    disable iff (!rst_n || power_fail)
    $fell(sda_oe) |-> !scl_in && scl_age_r < 4'd7;
  endproperty
  a_drive_end: assert property (p_drive_end) else $error("data released off a clock fall");

  property p_hold_high;
    disable iff (!rst_n || power_fail)
    scl_in && $past(scl_in) |-> $stable(sda_oe);
  endproperty
  a_hold_high: assert property (p_hold_high) else $error("data moved while clock high");

  property p_ack_hold;
    $rose(scl_in) && sda_oe |=> sda_oe[*4];
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("acknowledge not held");

  property p_lockout;
    power_fail[*4] |=> !sda_oe;
  endproperty
  a_lockout: assert property (p_lockout) else $error("bus driven in lockout");

  property p_pin_cause;
    $changed(square_wave_oe) |-> osc_age_r < 4'd8 || ack_age_r < 4'd8;
  endproperty
  a_pin_cause: assert property (p_pin_cause) else $error("pin moved without cause");

  c_ack: cover property ($rose(sda_oe));
  c_lock: cover property (power_fail[*4]);
  c_pin: cover property ($changed(square_wave_oe));
endmodule // rtc_core_monitor

bind rtc_core rtc_core_monitor rtc_core_monitor_inst (
  .clk             (clk),
  .rst_n           (rst_n),
  .scl_in          (scl_in),
  .sda_in          (sda_in),
  .sda_out         (sda_out),
  .sda_oe          (sda_oe),
  .osc_in          (osc_in),
  .power_fail      (power_fail),
  .square_wave_pin (square_wave_pin),
  .square_wave_oe  (square_wave_oe)
);
